// ==== core/ucp_regs.vh ====
`ifndef UCP_REGS_VH
`define UCP_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define UCP_OFF_CTRL      8'h00
`define UCP_OFF_STATUS    8'h04
`define UCP_OFF_COUNT     8'h08
`define UCP_OFF_DATA_A    8'h0C
`define UCP_OFF_DATA_B    8'h10
`define UCP_OFF_PRESCALE  8'h14
`define UCP_OFF_IRQ_MASK  8'h18

// ****************************************
// Control register fields
// ****************************************
`define UCP_CTRL_MODE_LSB 0
`define UCP_CTRL_MODE_MSB 6
`define UCP_CTRL_REQEN_BIT 7
`define UCP_CTRL_FRZ_BIT  8
`define UCP_CTRL_GPO_BIT  9
`define UCP_CTRL_MSB      9

// ****************************************
// Prescale register fields
// ****************************************
`define UCP_PRE_INT_LSB   0
`define UCP_PRE_INT_MSB   3
`define UCP_PRE_GLB_LSB   8
`define UCP_PRE_GLB_MSB   11
`define UCP_PRE_GEN_BIT   16

// ****************************************
// Status and mask fields
// ****************************************
`define UCP_ST_FLAG_BIT   0
`define UCP_ST_OVR_BIT    1
`define UCP_ST_W          2

// ****************************************
// Mode encodings
// ****************************************
`define UCP_MODE_GPO      7'h01
`define UCP_MODE_MOD_0    7'h10
`define UCP_MODE_MOD_1    7'h11
`define UCP_MODE_MODB_0   7'h50
`define UCP_MODE_MODB_1   7'h51
`define UCP_MODE_PWFMB_0  7'h58
`define UCP_MODE_PWFMB_1  7'h5A

// ****************************************
// Reset values and counter constants
// ****************************************
`define UCP_RST_CTRL      10'h000
`define UCP_RST_PRESCALE  17'h00000
`define UCP_RST_MASK      2'h0
`define UCP_BUF_START     1'b1

`endif

// ==== core/ucp_divider.v ====
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Tick divider: passes every ratio_m1+1-th input tick
// ****************************************
module ucp_divider #(
  parameter RW = 4                              // Ratio field width
) (
  input  wire          core_clk,
  input  wire          rst_n,
  input  wire          tick_in,
  input  wire [RW-1:0] ratio_m1,
  output wire          tick_out
);

  reg [RW-1:0] div_q;                           // Tick count within a division
  reg [RW-1:0] div_d;                           // Next tick count

  // Last tick of the division passes through
  assign tick_out = tick_in & (div_q >= ratio_m1);

  // Next count: wrap on the passed tick
  always @* begin
    div_d = div_q;
    if (tick_in) begin
      if (div_q >= ratio_m1) begin
        div_d = {RW{1'b0}};
      end else begin
        div_d = div_q + {{(RW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Count register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= {RW{1'b0}};
    end else begin
      div_q <= div_d;
    end
  end

endmodule // ucp_divider

`default_nettype wire

// ==== core/ucp_channel_timer.v ====
`timescale 1ns/10ps
`default_nettype none
`include "ucp_regs.vh"

module ucp_channel_timer #(
  parameter CW = 16,                            // Counter and data width
  parameter PW = 4                              // Prescale ratio field width
) (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         chan_out_q,
  output reg         event_req_q,
  output reg         irq_q
);

  // ****************************************
  // Mode decode helpers
  // ****************************************

  // Either code of a pair selects the same behaviour
  // Unbuffered modulus counter
  function is_modcnt;
    input [6:0] m;
    begin
      is_modcnt = (m == `UCP_MODE_MOD_0) || (m == `UCP_MODE_MOD_1);
    end
  endfunction

  // Buffered modulus counter
  function is_modcnt_buf;
    input [6:0] m;
    begin
      is_modcnt_buf = (m == `UCP_MODE_MODB_0) || (m == `UCP_MODE_MODB_1);
    end
  endfunction

  // Buffered width/frequency PWM
  function is_pwfmb;
    input [6:0] m;
    begin
      is_pwfmb = (m == `UCP_MODE_PWFMB_0) || (m == `UCP_MODE_PWFMB_1);
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [`UCP_CTRL_MSB:0]   ctrl_q;               // Mode, enable, freeze, output level
  reg [16:0]              pre_q;                // Prescaler ratios and global enable
  reg [`UCP_ST_W-1:0]     status_q;             // Sticky flag and overrun
  reg [`UCP_ST_W-1:0]     status_d;             // Next status
  reg [`UCP_ST_W-1:0]     mask_q;               // Interrupt mask
  reg [CW-1:0]            cnt_q;                // Internal counter
  reg [CW-1:0]            cnt_d;                // Next counter
  // Active pair drives the compares; buffered pair is what software writes
  reg [CW-1:0]            act_a_q;              // Active compare A
  reg [CW-1:0]            act_b_q;              // Active compare B
  reg [CW-1:0]            act_a_d;              // Next active A
  reg [CW-1:0]            act_b_d;              // Next active B
  reg [CW-1:0]            buf_a_q;              // Buffered compare A
  reg [CW-1:0]            buf_b_q;              // Buffered compare B
  reg                     period_end;           // Counter period completed
  reg                     reload;               // Buffered reload this cycle
  reg                     out_d;                // Next channel output
  reg [31:0]              rd_d;                 // Read mux
  reg                     hit;                  // Address is mapped

  wire [6:0]  mode     = ctrl_q[`UCP_CTRL_MODE_MSB:`UCP_CTRL_MODE_LSB];
  wire        req_en   = ctrl_q[`UCP_CTRL_REQEN_BIT];        // Event request enable
  wire        freeze   = ctrl_q[`UCP_CTRL_FRZ_BIT];          // Counting halted, count writable
  wire        buffered = is_modcnt_buf(mode) | is_pwfmb(mode); // Double-buffered compares
  wire        counting = is_modcnt(mode) | buffered;         // Any counter mode
  wire        acc      = psel & penable & pready;
  wire        wr_en    = acc & pwrite;
  wire        glb_tick;                          // Global prescaler output
  wire        ch_tick;                           // Channel prescaler output
  // Restart value of the buffered modes, widened to the counter
  wire [CW-1:0] one    = {{(CW-1){1'b0}}, `UCP_BUF_START};

  // ****************************************
  // Prescalers
  // ****************************************

  // Global stage divides the core clock
  ucp_divider #(.RW(PW)) u_glb_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick_in  (pre_q[`UCP_PRE_GEN_BIT]),
    .ratio_m1 (pre_q[`UCP_PRE_GLB_MSB:`UCP_PRE_GLB_LSB]),
    .tick_out (glb_tick)
  );

  // Channel stage divides the global ticks
  ucp_divider #(.RW(PW)) u_ch_div (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick_in  (glb_tick & ~freeze),
    .ratio_m1 (pre_q[`UCP_PRE_INT_MSB:`UCP_PRE_INT_LSB]),
    .tick_out (ch_tick)
  );

  // ****************************************
  // Counter and compare
  // ****************************************

  // Counter step, rollover and reload
  always @* begin
    cnt_d      = cnt_q;
    period_end = 1'b0;
    reload     = 1'b0;
    if (wr_en && (paddr == `UCP_OFF_COUNT) && freeze) begin
      cnt_d = pwdata[CW-1:0];
    end else if (ch_tick && counting) begin
      if (is_modcnt(mode)) begin
        // Unbuffered: clear to zero on A match
        if (cnt_q >= act_a_q) begin
          cnt_d      = {CW{1'b0}};
          period_end = 1'b1;
        end else begin
          cnt_d = cnt_q + one;
        end
      end else if (is_modcnt_buf(mode)) begin
        // Buffered modulus: restart at one
        // One, never zero, so the reload below still fires
        if (cnt_q >= act_a_q) begin
          cnt_d      = one;
          period_end = 1'b1;
        end else begin
          cnt_d = cnt_q + one;
        end
      end else begin
        // Width/frequency: run 1..B, restart at one even past B
        // A count forced above B also restarts here, with reload
        if (cnt_q >= act_b_q) begin
          cnt_d      = one;
          period_end = 1'b1;
        end else begin
          cnt_d = cnt_q + one;
        end
      end
      reload = buffered && (cnt_d == one);
    end
  end

  // Active compare values
  always @* begin
    if (!buffered) begin
      // Unbuffered modes use the data registers at once
      act_a_d = buf_a_q;
      act_b_d = buf_b_q;
    end else if (reload) begin
      // Buffered: take the new pair on the step to one
      act_a_d = buf_a_q;
      act_b_d = buf_b_q;
    end else begin
      // Hold the pair for the rest of the period
      act_a_d = act_a_q;
      act_b_d = act_b_q;
    end
  end

  // Output level per mode
  always @* begin
    if (is_pwfmb(mode)) begin
      // High from the A match to the end of the period
      out_d = (cnt_d >= act_a_d);
    end else if (counting) begin
      out_d = 1'b0;
    end else begin
      out_d = ctrl_q[`UCP_CTRL_GPO_BIT];
    end
  end

  // Counter, compare and output registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= {CW{1'b0}};
      act_a_q    <= {CW{1'b0}};
      act_b_q    <= {CW{1'b0}};
      chan_out_q <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      act_a_q    <= act_a_d;
      act_b_q    <= act_b_d;
      chan_out_q <= out_d;
    end
  end

  // ****************************************
  // Event flag and requests
  // ****************************************

  // Sticky flags: a new event beats a same-cycle clear
  always @* begin
    status_d = status_q;
    if (wr_en && (paddr == `UCP_OFF_STATUS)) begin
      status_d = status_q & ~pwdata[`UCP_ST_W-1:0];
    end
    if (period_end) begin
      status_d[`UCP_ST_FLAG_BIT] = 1'b1;
      if (status_q[`UCP_ST_FLAG_BIT]) begin
        status_d[`UCP_ST_OVR_BIT] = 1'b1;
      end
    end
  end

  // Status and request outputs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q    <= {`UCP_ST_W{1'b0}};
      event_req_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      status_q    <= status_d;
      // Both follow the next status, so they rise with the flag
      event_req_q <= status_d[`UCP_ST_FLAG_BIT] & req_en;
      irq_q       <= |(status_d & mask_q);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************

  // Read mux and address decode
  always @* begin
    rd_d = 32'h00000000;
    hit  = 1'b1;
    case (paddr)
      `UCP_OFF_CTRL:     rd_d[`UCP_CTRL_MSB:0] = ctrl_q;
      `UCP_OFF_STATUS:   rd_d[`UCP_ST_W-1:0]   = status_q;
      `UCP_OFF_COUNT:    rd_d[CW-1:0]          = cnt_q;
      // Data registers read back as written, not the active pair
      `UCP_OFF_DATA_A:   rd_d[CW-1:0]          = buf_a_q;
      `UCP_OFF_DATA_B:   rd_d[CW-1:0]          = buf_b_q;
      `UCP_OFF_PRESCALE: rd_d[16:0]            = pre_q;
      `UCP_OFF_IRQ_MASK: rd_d[`UCP_ST_W-1:0]   = mask_q;
      default:           hit                   = 1'b0;
    endcase
  end

  // One wait state, then ready with data or error
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= pwrite ? 32'h00000000 : rd_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Register writes at the completing edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `UCP_RST_CTRL;
      pre_q  <= `UCP_RST_PRESCALE;
      mask_q <= `UCP_RST_MASK;
      buf_a_q <= {CW{1'b0}};
      buf_b_q <= {CW{1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `UCP_OFF_CTRL:     ctrl_q <= pwdata[`UCP_CTRL_MSB:0];
        `UCP_OFF_PRESCALE: pre_q  <= pwdata[16:0];
        `UCP_OFF_IRQ_MASK: mask_q <= pwdata[`UCP_ST_W-1:0];
        `UCP_OFF_DATA_A:   buf_a_q <= pwdata[CW-1:0];
        `UCP_OFF_DATA_B:   buf_b_q <= pwdata[CW-1:0];
        // Count and status writes are taken by their own logic
        default:           buf_a_q <= buf_a_q;
      endcase
    end
  end

endmodule // ucp_channel_timer

`default_nettype wire

// ==== sim/ucp_channel_timer_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ucp_regs.vh"
// ***
// Port checker
// ***
module ucp_channel_timer_assertions (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        chan_out_q,
  input wire logic        event_req_q,
  input wire logic        irq_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Bus phases
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  sequence done_s; psel && penable && pready; endsequence
  sequence ctrl_wr_s; done_s ##0 (pwrite && paddr == `UCP_OFF_CTRL); endsequence
  ready_one_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_wait_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready) else $error("bad wait state");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_unmapped_a: assert property (done_s ##0 (paddr > `UCP_OFF_IRQ_MASK) |-> pslverr) else $error("no error");
  err_zero_a: assert property (done_s ##0 (pslverr && !pwrite) |-> prdata == 32'h0) else $error("error data");
  req_gate_a: assert property (
    ctrl_wr_s ##0 !pwdata[`UCP_CTRL_REQEN_BIT] |-> ##[1:2] !event_req_q) else $error("request not gated");
  irq_mask_a: assert property (
    done_s ##0 (pwrite && paddr == `UCP_OFF_IRQ_MASK && pwdata[1:0] == 2'h0) |-> ##[1:2] !irq_q)
    else $error("masked irq high");
  modcnt_out_a: assert property (
    ctrl_wr_s ##0 (pwdata[6:1] == 6'h08) |-> ##[1:2] !chan_out_q) else $error("counter mode output");
endmodule // ucp_channel_timer_assertions
`default_nettype wire

// ==== sim/ucp_channel_timer_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ucp_regs.vh"
module ucp_channel_timer_test;
  logic        core_clk, rst_n, psel, penable, pwrite, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd_q;
  wire  [31:0] prdata;
  wire         pready, pslverr, chan_out_q, event_req_q, irq_q;
  int          n_fail, n_tests, i;
  // Mode table: code, A, lowest and highest count, prescale
  logic [6:0]  md [6] = '{`UCP_MODE_PWFMB_0, `UCP_MODE_PWFMB_1, `UCP_MODE_MOD_0, `UCP_MODE_MOD_1,
                          `UCP_MODE_MODB_0, `UCP_MODE_MODB_1};
  logic [31:0] av [6] = '{32'h2, 32'h2, 32'h4, 32'h4, 32'h5, 32'h5};
  logic [31:0] lo [6] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h1, 32'h1};
  logic [31:0] hi [6] = '{32'h5, 32'h5, 32'h4, 32'h4, 32'h5, 32'h5};
  logic [31:0] pre [6] = '{32'h10000, 32'h10000, 32'h10000, 32'h10100, 32'h10000, 32'h10001};
  ucp_channel_timer u_ucp_channel_timer (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_out_q(chan_out_q), .event_req_q(event_req_q), .irq_q(irq_q));
  // ***
  // Tasks
  // ***
  task give_verdict;
    $display("Checks %0d, failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer, held until ready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge core_clk);
    if (n == 50) begin
      // No answer: count it and close the run
      n_fail++;
      $display("[ERR] %0t no ready from slave", $time);
      give_verdict;
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  task settle;
    repeat (3) @(posedge core_clk);
  endtask
  // Sample the counter and check its span
  task span(input logic [31:0] l, input logic [31:0] h);
    logic [31:0] mn, mx;
    mn = 32'hFFFFFFFF;
    mx = 32'h0;
    repeat (20) begin
      apb(1'b0, `UCP_OFF_COUNT, 32'h0);
      if (rd_q < mn) mn = rd_q;
      if (rd_q > mx) mx = rd_q;
    end
    chk(mn, l);
    chk(mx, h);
  endtask
  // ***
  // Clock, watchdog, tests
  // ***
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end
  initial begin
    rst_n <= 1'b0;
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`UCP_OFF_CTRL, 32'h0);
    rd(`UCP_OFF_STATUS, 32'h0);
    rd(`UCP_OFF_PRESCALE, 32'h0);
    rd(`UCP_OFF_IRQ_MASK, 32'h0);
    rd(8'h1C, 32'h0);
    chk(32'(err_q), 32'h1);
    wr(`UCP_OFF_COUNT, 32'h7);
    rd(`UCP_OFF_COUNT, 32'h0);
    wr(`UCP_OFF_CTRL, 32'h100);
    wr(`UCP_OFF_COUNT, 32'h7);
    rd(`UCP_OFF_COUNT, 32'h7);
    wr(`UCP_OFF_COUNT, 32'h1);
    wr(`UCP_OFF_CTRL, 32'h201);
    settle;
    chk(32'(chan_out_q), 32'h1);
    for (i = 0; i < 6; i++) begin
      // Data first, then enter the mode frozen with the count in range
      wr(`UCP_OFF_DATA_A, av[i]);
      wr(`UCP_OFF_DATA_B, 32'h5);
      wr(`UCP_OFF_CTRL, {25'h3, md[i]});
      wr(`UCP_OFF_PRESCALE, pre[i]);
      wr(`UCP_OFF_COUNT, av[i]);
      settle;
      chk(32'(chan_out_q), 32'(i < 2));
      wr(`UCP_OFF_COUNT, 32'h1);
      settle;
      chk(32'(chan_out_q), 32'h0);
      wr(`UCP_OFF_CTRL, {25'h0, md[i]});
      repeat (20) @(posedge core_clk);
      span(lo[i], hi[i]);
      if (i < 2) begin
        wr(`UCP_OFF_DATA_B, 32'h7);
        repeat (20) @(posedge core_clk);
        span(32'h1, 32'h7);
      end
    end
    wr(`UCP_OFF_CTRL, 32'h151);
    apb(1'b0, `UCP_OFF_STATUS, 32'h0);
    chk(rd_q & 32'h1, 32'h1);
    settle;
    chk(32'(event_req_q), 32'h0);
    wr(`UCP_OFF_CTRL, 32'h1D1);
    settle;
    chk(32'(event_req_q), 32'h1);
    chk(32'(irq_q), 32'h0);
    wr(`UCP_OFF_IRQ_MASK, 32'h1);
    settle;
    chk(32'(irq_q), 32'h1);
    wr(`UCP_OFF_IRQ_MASK, 32'h0);
    settle;
    chk(32'(irq_q), 32'h0);
    wr(`UCP_OFF_IRQ_MASK, 32'h1);
    wr(`UCP_OFF_STATUS, 32'h3);
    rd(`UCP_OFF_STATUS, 32'h0);
    chk(32'(irq_q), 32'h0);
    chk(32'(event_req_q), 32'h0);
    give_verdict;
  end
endmodule // ucp_channel_timer_test
bind ucp_channel_timer ucp_channel_timer_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chan_out_q(chan_out_q), .event_req_q(event_req_q), .irq_q(irq_q));
`default_nettype wire
